// ===== rtl/psef_edge.sv
`timescale 1ns/10ps
// ==========================================
// Per-bit edge detect with selectable polarity
module psef_edge #(
	parameter int WIDTH = 8
) (
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire logic [WIDTH-1:0] i_level,
	input wire logic [WIDTH-1:0] i_rise_sel,
	output logic [WIDTH-1:0] o_hit
);
	logic [WIDTH-1:0] prev_ff;

	// A zero-width level bus has no edges to find
	if (WIDTH < 1) begin : g_bad_width
		$error("psef_edge: WIDTH must be at least 1");
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			prev_ff <= '0;
		end else begin
			prev_ff <= i_level;
		end
	end

	// Rising when select is 1, falling when 0
	assign o_hit = (i_rise_sel & i_level & ~prev_ff) |
		(~i_rise_sel & ~i_level & prev_ff);
endmodule

// ===== rtl/psef_pkg.sv
package psef_pkg;
	// ==========================================
	// Register indices (byte-wide register port)
	localparam logic [7:0] ADDR_LIVE = 8'h0d;
	localparam logic [7:0] ADDR_MASK = 8'h0e;
	localparam logic [7:0] ADDR_POL = 8'h0f;
	localparam logic [7:0] ADDR_FLAG = 8'h10;
	// ==========================================
	// Field positions
	localparam int BIT_LOCK = 7;
	localparam int BIT_REF = 6;
	localparam int BIT_VCO = 5;
	localparam int BIT_SWB = 1;
	// Implemented bits; the rest are reserved
	localparam logic [7:0] SRC_BITS = 8'he2;
	// Masks and polarities keep their reserved storage bits
	localparam logic [7:0] CFG_BITS = 8'hff;
	// ==========================================
	// Reset values
	localparam logic [7:0] RST_MASK = 8'h00;
	localparam logic [7:0] RST_POL = 8'h00;
	localparam logic [7:0] RST_FLAG = 8'h00;
	localparam logic [7:0] RST_LIVE = 8'h00;
endpackage

// ===== rtl/psef_sync.sv
`timescale 1ns/10ps
// ==========================================
// Two-stage synchroniser for asynchronous sources
module psef_sync #(
	parameter int WIDTH = 4
) (
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] stage1_ff;
	logic [WIDTH-1:0] stage2_ff;

	// A zero-width source bus has nothing to carry
	if (WIDTH < 1) begin : g_bad_width
		$error("psef_sync: WIDTH must be at least 1");
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			stage1_ff <= '0;
			stage2_ff <= '0;
		end else begin
			stage1_ff <= i_async;
			stage2_ff <= stage1_ff;
		end
	end

	assign o_sync = stage2_ff;
endmodule

// ===== rtl/psef_top.sv
`timescale 1ns/10ps
module psef_top (
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire logic i_lock_dropped,
	input wire logic i_reference_missing,
	input wire logic i_vco_tuning,
	input wire logic i_switchback_to_main_ref,
	input wire logic i_irq_enable,
	input wire logic i_combine_all,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	output logic o_reg_hit,
	output logic o_event_irq
);
	// ==========================================
	// Source synchronisation
	logic [3:0] src_raw;
	logic [3:0] src_sync;
	logic [7:0] live;
	logic [7:0] live_ff;
	logic [7:0] hit;
	logic [7:0] mask_ff;
	logic [7:0] pol_ff;
	logic [7:0] flag_ff;
	logic [7:0] nxt_flag;
	logic [7:0] active;
	logic [7:0] rdata_ff;
	logic hit_ff;
	logic irq_ff;
	logic nxt_irq;
	logic wr_mask;
	logic wr_pol;
	logic wr_flag;

	// ==========================================
	// Register decode
	// One compare shared by every write strobe
	function automatic logic reg_sel(input logic strobe, input logic [7:0] addr,
		input logic [7:0] idx);
		return strobe && (addr == idx);
	endfunction

	// Writes to live status and unmapped indices decode to nothing
	assign wr_mask = reg_sel(i_reg_wr, i_reg_addr, psef_pkg::ADDR_MASK);
	assign wr_pol = reg_sel(i_reg_wr, i_reg_addr, psef_pkg::ADDR_POL);
	assign wr_flag = reg_sel(i_reg_wr, i_reg_addr, psef_pkg::ADDR_FLAG);

	assign src_raw = {i_lock_dropped, i_reference_missing, i_vco_tuning,
		i_switchback_to_main_ref};

	psef_sync #(
		.WIDTH(4)
	) u_sync (
		.i_clock(i_clock),
		.i_rst_b(i_rst_b),
		.i_async(src_raw),
		.o_sync(src_sync)
	);

	// ==========================================
	// Live view, lock loss suppressed while reference is missing
	always_comb begin
		live = 8'h00;
		live[psef_pkg::BIT_LOCK] = src_sync[3] & ~src_sync[2];
		live[psef_pkg::BIT_REF] = src_sync[2];
		live[psef_pkg::BIT_VCO] = src_sync[1];
		live[psef_pkg::BIT_SWB] = src_sync[0];
	end

	// Registered so reads and edges see one consistent view
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			live_ff <= psef_pkg::RST_LIVE;
		end else begin
			live_ff <= live;
		end
	end

	psef_edge #(
		.WIDTH(8)
	) u_edge (
		.i_clock(i_clock),
		.i_rst_b(i_rst_b),
		.i_level(live_ff),
		.i_rise_sel(pol_ff),
		.o_hit(hit)
	);

	// ==========================================
	// Configuration registers
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			mask_ff <= psef_pkg::RST_MASK;
		end else if (wr_mask) begin
			mask_ff <= i_reg_wdata & psef_pkg::CFG_BITS;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pol_ff <= psef_pkg::RST_POL;
		end else if (wr_pol) begin
			pol_ff <= i_reg_wdata & psef_pkg::CFG_BITS;
		end
	end

	// ==========================================
	// Sticky flags, set by edges only while irq enable is high; a new edge wins over a clear in the same cycle
	always_comb begin
		nxt_flag = flag_ff;
		if (wr_flag) begin
			nxt_flag = flag_ff & i_reg_wdata;
		end
		if (i_irq_enable) begin
			nxt_flag = nxt_flag | hit;
		end
		nxt_flag = nxt_flag & psef_pkg::SRC_BITS;
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			flag_ff <= psef_pkg::RST_FLAG;
		end else begin
			flag_ff <= nxt_flag;
		end
	end

	// ==========================================
	// Combined interrupt
	always_comb begin
		active = flag_ff & ~mask_ff & psef_pkg::SRC_BITS;
		if (!i_irq_enable) begin
			nxt_irq = 1'b0;
		end else if (i_combine_all) begin
			// All-masked in AND mode raises nothing
			nxt_irq = (active != 8'h00) &&
				((active | ~(~mask_ff & psef_pkg::SRC_BITS)) == 8'hff);
		end else begin
			nxt_irq = (active != 8'h00);
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= nxt_irq;
		end
	end

	assign o_event_irq = irq_ff;

	// ==========================================
	// Read port, one cycle latency; unmapped reads return zero
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rdata_ff <= 8'h00;
			hit_ff <= 1'b0;
		end else if (i_reg_rd) begin
			hit_ff <= 1'b1;
			case (i_reg_addr)
				psef_pkg::ADDR_LIVE: begin
					rdata_ff <= live_ff;
				end
				psef_pkg::ADDR_MASK: begin
					rdata_ff <= mask_ff;
				end
				psef_pkg::ADDR_POL: begin
					rdata_ff <= pol_ff;
				end
				psef_pkg::ADDR_FLAG: begin
					rdata_ff <= flag_ff;
				end
				default: begin
					rdata_ff <= 8'h00;
					hit_ff <= 1'b0;
				end
			endcase
		end
	end

	assign o_reg_rdata = rdata_ff;
	assign o_reg_hit = hit_ff;
endmodule

// ===== sim/psef_assertions.sv
`timescale 1ns/10ps
// ====
// Port checks
module psef_assertions (
	input logic i_clock,
	input logic i_rst_b,
	input logic i_lock_dropped,
	input logic i_reference_missing,
	input logic i_irq_enable,
	input logic i_reg_wr,
	input logic i_reg_rd,
	input logic [7:0] i_reg_addr,
	input logic [7:0] o_reg_rdata,
	input logic o_reg_hit,
	input logic o_event_irq
);
	default clocking @(posedge i_clock);
	endclocking
	default disable iff (!i_rst_b);
	sequence live_rd;
		i_reg_rd && i_reg_addr == 8'h0d;
	endsequence
	sequence flag_rd;
		i_reg_rd && !i_reg_wr && i_reg_addr == 8'h10;
	endsequence
	a_irq_gated: assert property (
		!i_irq_enable [*2] |=> !o_event_irq) else $error("irq on");
	a_unmapped_rd: assert property (
		i_reg_rd && i_reg_addr > 8'h10 |=> !o_reg_hit && !o_reg_rdata) else $error("unmapped");
	a_mapped_hit: assert property (
		i_reg_rd && i_reg_addr inside {[8'h0d:8'h10]} |=> o_reg_hit) else $error("no hit");
	a_live_resv: assert property (
		live_rd |=> !(o_reg_rdata & 8'h1d)) else $error("live resv");
	a_flag_resv: assert property (
		i_reg_rd && i_reg_addr == 8'h10 |=> !(o_reg_rdata & 8'h1d)) else $error("flag resv");
	// Five edges covers the sync and live stages
	a_ref_wins: assert property (
		i_reference_missing [*5] ##0 live_rd |=> o_reg_rdata[7:6] == 2'h1) else $error("ref");
	a_lock_live: assert property (
		(i_lock_dropped && !i_reference_missing) [*5] ##0 live_rd |=> o_reg_rdata[7])
		else $error("lock");
	a_rd_holds: assert property (
		!i_reg_rd |=> $stable(o_reg_rdata) && $stable(o_reg_hit)) else $error("rdata moved");
	// No write between two flag reads, so no set bit may vanish
	a_flag_hold: assert property (
		flag_rd ##1 !i_reg_wr ##1 flag_rd
		|=> (o_reg_rdata & $past(o_reg_rdata, 2)) == $past(o_reg_rdata, 2))
		else $error("flag dropped");
endmodule

// ===== sim/tb.sv
`timescale 1ns/10ps
// ====
// Bench
module tb;
	typedef struct packed {logic [3:0] s0, s1; logic [7:0] pol, msk;
		logic en, cmb; logic [7:0] fl; logic irq;} psef_row_t;
	// Sources as lock, ref, vco, switchback
	logic [3:0] src = 4'h0;
	logic i_clock = 1'h0, i_rst_b = 1'h0, i_irq_enable = 1'h0, i_combine_all = 1'h0;
	logic i_reg_wr = 1'h0, i_reg_rd = 1'h0, o_reg_hit, o_event_irq;
	logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata, rv, ev;
	int failures = 0, n_tests = 0;
	psef_row_t rows[7] = '{
		'{4'h0,4'hb,8'hff,8'h00,1'h1,1'h0,8'ha2,1'h1},
		'{4'hb,4'h0,8'h00,8'h00,1'h1,1'h0,8'ha2,1'h1},
		'{4'h0,4'h4,8'hff,8'ha2,1'h1,1'h1,8'h40,1'h1},
		'{4'h0,4'h4,8'hff,8'h00,1'h1,1'h1,8'h40,1'h0},
		'{4'h0,4'hf,8'hff,8'h00,1'h0,1'h0,8'h00,1'h0},
		'{4'h0,4'hb,8'hff,8'he2,1'h1,1'h0,8'ha2,1'h0},
		'{4'h0,4'hb,8'h00,8'h00,1'h1,1'h0,8'h00,1'h0}};
	psef_top u_dut (
		.i_lock_dropped(src[3]),
		.i_reference_missing(src[2]),
		.i_vco_tuning(src[1]),
		.i_switchback_to_main_ref(src[0]),
		.*
	);
	always #4 i_clock = ~i_clock;
	// Idle cycle after each access so a strobe is never set twice at once
	task automatic acc(input logic w, input logic [7:0] a, d);
		i_reg_wr = w;
		i_reg_rd = !w;
		i_reg_addr = a;
		i_reg_wdata = d;
		@(negedge i_clock);
		i_reg_wr = 1'h0;
		i_reg_rd = 1'h0;
		rv = o_reg_rdata;
		@(negedge i_clock);
	endtask
	task automatic chk(input logic [7:0] got, exp, input string nm);
		n_tests++;
		failures += (got !== exp);
		if (got !== exp) $display("mismatch %s exp %h got %h", nm, exp, got);
	endtask
	task rst;
		i_rst_b = 1'h0;
		repeat (20) @(negedge i_clock);
		i_rst_b = 1'h1;
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		rst;
		foreach (rows[i]) begin
			i_irq_enable = rows[i].en;
			i_combine_all = rows[i].cmb;
			acc(1'h1, 8'h0f, rows[i].pol);
			acc(1'h1, 8'h0e, rows[i].msk);
			acc(1'h0, 8'h0f, 8'h00);
			chk(rv, rows[i].pol, "polarity");
			acc(1'h0, 8'h0e, 8'h00);
			chk(rv, rows[i].msk, "mask");
			src = rows[i].s0;
			repeat (6) @(negedge i_clock);
			acc(1'h1, 8'h10, 8'h00);
			src = rows[i].s1;
			repeat (8) @(negedge i_clock);
			acc(1'h0, 8'h10, 8'h00);
			chk(rv, rows[i].fl, "flags");
			chk({7'h0, o_event_irq}, {7'h0, rows[i].irq}, "irq");
			acc(1'h0, 8'h0d, 8'h00);
			// Lock loss hidden while the reference is missing
			ev = {rows[i].s1[3] & ~rows[i].s1[2], rows[i].s1[2:1], 3'h0, rows[i].s1[0], 1'h0};
			chk(rv, ev, "live");
			$display("row %0d done", i);
		end
		// Falling edges under polarity 0 set three flags
		src = 4'h0;
		repeat (8) @(negedge i_clock);
		acc(1'h1, 8'h10, 8'h7f);
		acc(1'h1, 8'h0d, 8'hff);
		acc(1'h0, 8'h10, 8'h00);
		chk(rv, 8'h22, "flag keep");
		acc(1'h0, 8'h10, 8'h00);
		chk(rv, 8'h22, "flag hold");
		chk({7'h0, o_event_irq}, 8'h01, "irq any");
		i_irq_enable = 1'h0;
		repeat (2) @(negedge i_clock);
		chk({7'h0, o_event_irq}, 8'h00, "irq off");
		acc(1'h0, 8'h11, 8'h00);
		chk({rv, o_reg_hit}, 9'h000, "unmapped");
		$display("write cases done");
		rst;
		acc(1'h0, 8'h10, 8'h00);
		chk(rv, 8'h00, "flag reset");
		$display("reset done");
		end_of_test;
	end
endmodule
bind psef_top psef_assertions u_chk (.*);
